/* File: pcl_pkg.sv */
// Package with register map, field layout, reset values and carriers of the PLL config block
package pcl_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] PCL_ADDR_CTRL  = 8'h00;
  localparam logic [7:0] PCL_ADDR_BWC   = 8'h04;
  localparam logic [7:0] PCL_ADDR_MULH  = 8'h08;
  localparam logic [7:0] PCL_ADDR_MULL  = 8'h0C;
  localparam logic [7:0] PCL_ADDR_VRS   = 8'h10;
  localparam logic [7:0] PCL_ADDR_RDS   = 8'h14;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int PCL_CTRL_IE_BIT   = 7;
  localparam int PCL_CTRL_FLAG_BIT = 6;
  localparam int PCL_CTRL_ON_BIT   = 5;
  localparam int PCL_CTRL_BCS_BIT  = 4;
  localparam int PCL_CTRL_PRE_LSB  = 2;
  localparam int PCL_CTRL_VPR_LSB  = 0;

  // ****************************************
  // Bandwidth control register fields
  // ****************************************
  localparam int PCL_BWC_AUTO_BIT = 7;
  localparam int PCL_BWC_LOCK_BIT = 6;
  localparam int PCL_BWC_ACQ_BIT  = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic       PCL_RST_ON   = 1'b1;
  localparam logic [3:0] PCL_RST_MULH = 4'h0;
  localparam logic [7:0] PCL_RST_MULL = 8'h40;
  localparam logic [7:0] PCL_RST_VRS  = 8'h40;
  localparam logic [3:0] PCL_RST_RDS  = 4'h1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic lock_detect;
    logic track_detect;
  } pcl_stat_t;

  typedef struct packed {
    logic        pll_power;
    logic        pll_enable;
    logic        base_clock_choice;
    logic [1:0]  prescale;
    logic [1:0]  vco_pow2;
    logic [11:0] feedback_factor;
    logic [7:0]  vco_range_factor;
    logic [3:0]  ref_divisor;
    logic        auto_mode;
    logic        capture_phase_select;
  } pcl_cfg_t;

endpackage : pcl_pkg

/* File: pcl_top.sv */
// PLL programming and lock status registers behind an APB slave
// Functional notes
// RULE_01: In auto mode lock bit is read-only and follows lock detector.
// RULE_02: Lock bit reads zero when auto is off; reset clears it.
// RULE_03: Software always writes zero to the lock bit position.
// RULE_04: In auto mode acquisition bit is read-only, shows tracking (1) or acquisition.
// RULE_05: In manual mode acquisition bit is read/write and drives loop mode.
// RULE_06: Manual acquisition value is kept during auto mode and restored after.
// RULE_07: Reset clears acquisition bit, loop starts in acquisition.
// RULE_08: Multiplier zero acts as one; reset loads 64.
// RULE_09: Multiplier bytes ignore writes while PLL is on.
// RULE_10: Upper nibble of multiplier high and divider registers reads zero.
// RULE_11: VCO range register ignores writes while PLL is on.
// RULE_12: Range zero disables PLL, clears and blocks base clock select.
// RULE_13: Reset loads VCO range factor of 64.
// RULE_14: Reference divider zero acts as one.
// RULE_15: Divider ignores writes while PLL on; reset divides by one.
// RULE_16: In auto mode each lock change sets flag; enable raises interrupt.
// RULE_17: Flag sets on lock change whatever the interrupt enable.
// RULE_18: Auto off suppresses interrupt and flag reads zero.
// RULE_19: Base clock select accepted even when unlocked.
// RULE_20: Wait mode changes no setting; only software writes change them.
// RULE_21: In break with clear enable low, control reads keep the flag.
// RULE_22: A read of the control register clears the flag, except as in RULE_21.
// RULE_23: Select refused while PLL off; PLL off refused while select set.
// RULE_24: Multiplier is 12 bits, high register bits 11:8, low 7:0.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns

module pcl_top
  import pcl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pcl_stat_t   pll_stat,
  input  wire logic        break_state,
  input  wire logic        break_flag_clear_enable,
  output pcl_cfg_t         pll_cfg,
  output logic             pll_irq
);

  // ****************************************
  // State
  // ****************************************
  logic        pll_irq_enable_q;
  logic        pll_irq_enable_d;
  logic        pll_change_flag_q;
  logic        pll_change_flag_d;
  logic        pll_power_q;
  logic        pll_power_d;
  logic        base_clock_choice_q;
  logic        base_clock_choice_d;
  logic [1:0]  prescale_q;
  logic [1:0]  prescale_d;
  logic [1:0]  vco_pow2_q;
  logic [1:0]  vco_pow2_d;
  logic        auto_q;
  logic        auto_d;
  logic        lock_q;
  logic        lock_d;
  logic        acq_manual_q;
  logic        acq_manual_d;
  logic [3:0]  mul_high_q;
  logic [3:0]  mul_high_d;
  logic [7:0]  mul_low_q;
  logic [7:0]  mul_low_d;
  logic [7:0]  vco_range_factor_q;
  logic [7:0]  vco_range_factor_d;
  logic [3:0]  ref_divisor_q;
  logic [3:0]  ref_divisor_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  pcl_cfg_t    cfg_q;
  pcl_cfg_t    cfg_d;
  logic        irq_q;
  logic        irq_d;

  logic        setup_rd;
  logic        wr_done;
  logic        rd_done;
  logic        mapped;
  logic        sel_ctrl;
  logic        sel_bwc;
  logic        sel_mulh;
  logic        sel_mull;
  logic        sel_vrs;
  logic        sel_rds;
  logic        bcs_set_ok;
  logic        power_hold;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  logic        capture_phase;
  logic [11:0] feedback_raw;

  // ****************************************
  // APB decode
  // ****************************************
  assign setup_rd = psel && !penable && !pwrite;
  assign wr_done  = psel && penable && pwrite;
  assign rd_done  = psel && penable && !pwrite;
  assign wbyte    = pwdata[7:0];
  assign pready   = 1'b1;
  assign prdata   = rdata_q;

  always_comb begin
    sel_ctrl = 1'b0;
    sel_bwc  = 1'b0;
    sel_mulh = 1'b0;
    sel_mull = 1'b0;
    sel_vrs  = 1'b0;
    sel_rds  = 1'b0;
    if (paddr == PCL_ADDR_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (paddr == PCL_ADDR_BWC) begin
      sel_bwc = 1'b1;
    end else if (paddr == PCL_ADDR_MULH) begin
      sel_mulh = 1'b1;
    end else if (paddr == PCL_ADDR_MULL) begin
      sel_mull = 1'b1;
    end else if (paddr == PCL_ADDR_VRS) begin
      sel_vrs = 1'b1;
    end else if (paddr == PCL_ADDR_RDS) begin
      sel_rds = 1'b1;
    end
  end

  assign mapped  = sel_ctrl || sel_bwc || sel_mulh || sel_mull || sel_vrs || sel_rds;
  assign pslverr = psel && penable && !mapped;

  // Loop mode: detector in auto, stored manual value otherwise
  assign capture_phase = auto_q ? pll_stat.track_detect : acq_manual_q; // RULE_04 RULE_05
  assign feedback_raw  = {mul_high_d, mul_low_d}; // RULE_24

  // ****************************************
  // Read data, captured in the setup phase
  // ****************************************
  always_comb begin
    rd_byte = 8'h00;
    if (sel_ctrl) begin
      rd_byte[PCL_CTRL_IE_BIT]       = pll_irq_enable_q && auto_q;
      rd_byte[PCL_CTRL_FLAG_BIT]     = pll_change_flag_q && auto_q; // RULE_18
      rd_byte[PCL_CTRL_ON_BIT]       = pll_power_q;
      rd_byte[PCL_CTRL_BCS_BIT]      = base_clock_choice_q;
      rd_byte[PCL_CTRL_PRE_LSB +: 2] = prescale_q;
      rd_byte[PCL_CTRL_VPR_LSB +: 2] = vco_pow2_q;
    end else if (sel_bwc) begin
      rd_byte[PCL_BWC_AUTO_BIT] = auto_q;
      rd_byte[PCL_BWC_LOCK_BIT] = lock_q && auto_q; // RULE_01 RULE_02
      rd_byte[PCL_BWC_ACQ_BIT]  = capture_phase; // RULE_04 RULE_05
    end else if (sel_mulh) begin
      rd_byte[3:0] = mul_high_q; // RULE_10
    end else if (sel_mull) begin
      rd_byte = mul_low_q;
    end else if (sel_vrs) begin
      rd_byte = vco_range_factor_q;
    end else if (sel_rds) begin
      rd_byte[3:0] = ref_divisor_q; // RULE_10
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (setup_rd) begin
      rdata_d = {24'h00_0000, rd_byte};
    end
  end

  // ****************************************
  // Control register next state
  // ****************************************
  assign bcs_set_ok = pll_power_q && (vco_range_factor_q != 8'h00); // RULE_12 RULE_23
  assign power_hold = base_clock_choice_q; // RULE_23

  always_comb begin
    pll_irq_enable_d    = pll_irq_enable_q;
    pll_power_d         = pll_power_q;
    base_clock_choice_d = base_clock_choice_q;
    prescale_d          = prescale_q;
    vco_pow2_d          = vco_pow2_q;
    if (wr_done && sel_ctrl) begin
      if (auto_q) begin
        pll_irq_enable_d = wbyte[PCL_CTRL_IE_BIT];
      end
      if (!(power_hold && !wbyte[PCL_CTRL_ON_BIT])) begin
        pll_power_d = wbyte[PCL_CTRL_ON_BIT]; // RULE_23
      end
      if (!wbyte[PCL_CTRL_BCS_BIT]) begin
        base_clock_choice_d = 1'b0;
      end else if (bcs_set_ok) begin
        base_clock_choice_d = 1'b1; // RULE_19 RULE_23 RULE_12
      end
      if (!pll_power_q) begin
        prescale_d = wbyte[PCL_CTRL_PRE_LSB +: 2];
        vco_pow2_d = wbyte[PCL_CTRL_VPR_LSB +: 2];
      end
    end
    if (vco_range_factor_q == 8'h00) begin
      base_clock_choice_d = 1'b0; // RULE_12
    end
    if (!auto_q) begin
      pll_irq_enable_d = 1'b0;
    end
  end

  // ****************************************
  // Bandwidth control next state
  // ****************************************
  always_comb begin
    auto_d       = auto_q;
    acq_manual_d = acq_manual_q;
    if (wr_done && sel_bwc) begin
      auto_d = wbyte[PCL_BWC_AUTO_BIT];
      if (!auto_q) begin
        acq_manual_d = wbyte[PCL_BWC_ACQ_BIT]; // RULE_05 RULE_06
      end
      // Lock bit position is a test hook; writes there are dropped
      // RULE_03
    end
  end

  // ****************************************
  // Divider programming next state
  // ****************************************
  always_comb begin
    mul_high_d         = mul_high_q;
    mul_low_d          = mul_low_q;
    vco_range_factor_d = vco_range_factor_q;
    ref_divisor_d      = ref_divisor_q;
    if (wr_done && !pll_power_q) begin // RULE_09 RULE_11 RULE_15
      if (sel_mulh) begin
        mul_high_d = wbyte[3:0]; // RULE_10 RULE_24
      end else if (sel_mull) begin
        mul_low_d = wbyte;
      end else if (sel_vrs) begin
        vco_range_factor_d = wbyte;
      end else if (sel_rds) begin
        ref_divisor_d = wbyte[3:0]; // RULE_10
      end
    end
  end

  // ****************************************
  // Lock change flag next state
  // ****************************************
  always_comb begin
    pll_change_flag_d = pll_change_flag_q;
    // Clear only what the read returned, so a later set is not lost
    if (rd_done && sel_ctrl && rdata_q[PCL_CTRL_FLAG_BIT]) begin // RULE_22
      if (!break_state || break_flag_clear_enable) begin // RULE_21
        pll_change_flag_d = 1'b0;
      end
    end
    if (auto_q && (lock_d != lock_q)) begin
      pll_change_flag_d = 1'b1; // RULE_16 RULE_17
    end
    if (!auto_q) begin
      pll_change_flag_d = 1'b0; // RULE_18
    end
  end

  // Lock indicator follows the detector only in auto mode
  assign lock_d = auto_q ? pll_stat.lock_detect : 1'b0; // RULE_01 RULE_02

  // ****************************************
  // Outputs to the analog loop
  // ****************************************
  always_comb begin
    cfg_d.pll_power            = pll_power_d;
    cfg_d.pll_enable           = pll_power_d && (vco_range_factor_d != 8'h00); // RULE_12
    cfg_d.base_clock_choice    = base_clock_choice_d;
    cfg_d.prescale             = prescale_d;
    cfg_d.vco_pow2             = vco_pow2_d;
    cfg_d.feedback_factor      = (feedback_raw == 12'h000) ? 12'h001 : feedback_raw; // RULE_08
    cfg_d.vco_range_factor     = vco_range_factor_d;
    cfg_d.ref_divisor          = (ref_divisor_d == 4'h0) ? 4'h1 : ref_divisor_d; // RULE_14
    cfg_d.auto_mode            = auto_d;
    cfg_d.capture_phase_select = auto_d ? pll_stat.track_detect : acq_manual_d;
    irq_d = auto_d && pll_irq_enable_d && pll_change_flag_d; // RULE_16 RULE_18
  end

  assign pll_cfg = cfg_q;
  assign pll_irq = irq_q;

  // ****************************************
  // Registers
  // ****************************************
  // No wait mode input: standby leaves every setting as it is // RULE_20
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pll_irq_enable_q    <= 1'b0;
      pll_change_flag_q   <= 1'b0;
      pll_power_q         <= PCL_RST_ON;
      base_clock_choice_q <= 1'b0;
      prescale_q          <= 2'h0;
      vco_pow2_q          <= 2'h0;
    end else begin
      pll_irq_enable_q    <= pll_irq_enable_d;
      pll_change_flag_q   <= pll_change_flag_d;
      pll_power_q         <= pll_power_d;
      base_clock_choice_q <= base_clock_choice_d;
      prescale_q          <= prescale_d;
      vco_pow2_q          <= vco_pow2_d;
    end
  end

  // ****************************************
  // Bandwidth control registers
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      auto_q       <= 1'b0;
      lock_q       <= 1'b0; // RULE_02
      acq_manual_q <= 1'b0; // RULE_07
    end else begin
      auto_q       <= auto_d;
      lock_q       <= lock_d;
      acq_manual_q <= acq_manual_d;
    end
  end

  // ****************************************
  // Divider programming registers
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mul_high_q         <= PCL_RST_MULH; // RULE_08
      mul_low_q          <= PCL_RST_MULL; // RULE_08
      vco_range_factor_q <= PCL_RST_VRS; // RULE_13
      ref_divisor_q      <= PCL_RST_RDS; // RULE_15
    end else begin
      mul_high_q         <= mul_high_d;
      mul_low_q          <= mul_low_d;
      vco_range_factor_q <= vco_range_factor_d;
      ref_divisor_q      <= ref_divisor_d;
    end
  end

  // ****************************************
  // Read data register
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q.pll_power            <= PCL_RST_ON;
      cfg_q.pll_enable           <= PCL_RST_ON;
      cfg_q.base_clock_choice    <= 1'b0;
      cfg_q.prescale             <= 2'h0;
      cfg_q.vco_pow2             <= 2'h0;
      cfg_q.feedback_factor      <= {PCL_RST_MULH, PCL_RST_MULL};
      cfg_q.vco_range_factor     <= PCL_RST_VRS;
      cfg_q.ref_divisor          <= PCL_RST_RDS;
      cfg_q.auto_mode            <= 1'b0;
      cfg_q.capture_phase_select <= 1'b0;
      irq_q                      <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      irq_q <= irq_d;
    end
  end

endmodule : pcl_top

/* File: pcl_chk.sv */
// Assertion checker for the PLL configuration and lock status block
`timescale 1ns/1ns
module pcl_chk
  import pcl_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire pcl_stat_t   pll_stat,
  input wire logic        break_state,
  input wire logic        break_flag_clear_enable,
  input wire pcl_cfg_t    pll_cfg,
  input wire logic        pll_irq
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_fb_hold; pll_cfg.pll_power |=> $stable(pll_cfg.feedback_factor); endproperty
  a_fb_hold: assert property (p_fb_hold) else $error("multiplier changed while on");
  property p_rng_hold; pll_cfg.pll_power |=> $stable(pll_cfg.vco_range_factor); endproperty
  a_rng_hold: assert property (p_rng_hold) else $error("range changed while on");
  property p_div_hold; pll_cfg.pll_power |=> $stable(pll_cfg.ref_divisor); endproperty
  a_div_hold: assert property (p_div_hold) else $error("divisor changed while on");
  property p_no_zero; pll_cfg.feedback_factor != 12'h000 && pll_cfg.ref_divisor != 4'h0;
  endproperty
  a_no_zero: assert property (p_no_zero) else $error("zero factor reached pll");
  property p_rng_zero;
    pll_cfg.vco_range_factor == 8'h00 |-> !pll_cfg.base_clock_choice && !pll_cfg.pll_enable;
  endproperty
  a_rng_zero: assert property (p_rng_zero) else $error("zero range left pll usable");
  property p_bcs_on;
    pll_cfg.base_clock_choice |-> pll_cfg.pll_power && $past(pll_cfg.pll_power);
  endproperty
  a_bcs_on: assert property (p_bcs_on) else $error("base clock chosen with pll off");
  property p_irq_off; !pll_cfg.auto_mode [*2] |-> !pll_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt in manual mode");
  property p_acq_wr;
    !pll_cfg.auto_mode && $past(!pll_cfg.auto_mode) && $changed(pll_cfg.capture_phase_select)
      |-> $past(psel && penable && pwrite && paddr == PCL_ADDR_BWC);
  endproperty
  a_acq_wr: assert property (p_acq_wr) else $error("loop mode changed without write");
endmodule : pcl_chk

bind pcl_top pcl_chk pcl_chk_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pll_stat(pll_stat), .break_state(break_state),
  .break_flag_clear_enable(break_flag_clear_enable), .pll_cfg(pll_cfg), .pll_irq(pll_irq));

/* File: pcl_top_bench.sv */
// Self-checking testbench for the PLL configuration and lock status block
`timescale 1ns/1ns
module pcl_top_bench
  import pcl_pkg::*;
;
  logic        ref_clk = 1'b0, rst = 1'b1, brk = 1'b0, bfce = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, pll_irq, slv;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  pcl_stat_t   pll_stat = '0;
  pcl_cfg_t    pll_cfg;
  int          err_count = 0, n_checks = 0;

  always #5 ref_clk = ~ref_clk;

  pcl_top pcl_top_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pll_stat(pll_stat), .break_state(brk),
    .break_flag_clear_enable(bfce), .pll_cfg(pll_cfg), .pll_irq(pll_irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      end_sim();
    end
    rdv = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rdv, exp);
  endtask : rd

  task automatic drv(input logic lk, input logic tr, input logic b, input logic f);
    @(posedge ref_clk);
    pll_stat <= {lk, tr};
    brk      <= b;
    bfce     <= f;
    repeat (4) @(posedge ref_clk);
  endtask : drv

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(PCL_ADDR_CTRL, 32'h20);
    rd(PCL_ADDR_BWC, 32'h00);
    rd(PCL_ADDR_MULL, 32'h40);
    rd(PCL_ADDR_VRS, 32'h40);
    rd(PCL_ADDR_RDS, 32'h01);
    rd(8'h18, 32'h00);
    chk({31'h0, slv}, 32'h1);
  endtask : t_reset

  task automatic t_prog();
    wr(PCL_ADDR_MULL, 8'h00);
    wr(PCL_ADDR_VRS, 8'h00);
    wr(PCL_ADDR_RDS, 8'h05);
    rd(PCL_ADDR_MULL, 32'h40);
    rd(PCL_ADDR_VRS, 32'h40);
    rd(PCL_ADDR_RDS, 32'h01);
    wr(PCL_ADDR_CTRL, 8'h30);
    rd(PCL_ADDR_CTRL, 32'h30);
    wr(PCL_ADDR_CTRL, 8'h00);
    rd(PCL_ADDR_CTRL, 32'h20);
    wr(PCL_ADDR_CTRL, 8'h00);
    wr(PCL_ADDR_CTRL, 8'h10);
    rd(PCL_ADDR_CTRL, 32'h00);
    wr(PCL_ADDR_MULH, 8'hFF);
    wr(PCL_ADDR_MULL, 8'h00);
    rd(PCL_ADDR_MULH, 32'h0F);
    chk({20'h0, pll_cfg.feedback_factor}, 32'hF00);
    wr(PCL_ADDR_MULH, 8'h00);
    rd(PCL_ADDR_MULL, 32'h00);
    chk({20'h0, pll_cfg.feedback_factor}, 32'h001);
    wr(PCL_ADDR_RDS, 8'hF0);
    rd(PCL_ADDR_RDS, 32'h00);
    chk({28'h0, pll_cfg.ref_divisor}, 32'h1);
    wr(PCL_ADDR_VRS, 8'h00);
    wr(PCL_ADDR_CTRL, 8'h20);
    wr(PCL_ADDR_CTRL, 8'h30);
    rd(PCL_ADDR_CTRL, 32'h20);
    chk({31'h0, pll_cfg.pll_enable}, 32'h0);
    wr(PCL_ADDR_CTRL, 8'h00);
    wr(PCL_ADDR_VRS, 8'h40);
  endtask : t_prog

  task automatic t_acq();
    wr(PCL_ADDR_BWC, 8'h20);
    rd(PCL_ADDR_BWC, 32'h20);
    chk({31'h0, pll_cfg.capture_phase_select}, 32'h1);
    drv(1'b0, 1'b1, 1'b0, 1'b0);
    wr(PCL_ADDR_BWC, 8'hA0);
    rd(PCL_ADDR_BWC, 32'hA0);
    drv(1'b0, 1'b0, 1'b0, 1'b0);
    rd(PCL_ADDR_BWC, 32'h80);
    wr(PCL_ADDR_BWC, 8'h80);
    wr(PCL_ADDR_BWC, 8'h00);
    rd(PCL_ADDR_BWC, 32'h20);
    wr(PCL_ADDR_BWC, 8'h00);
  endtask : t_acq

  task automatic t_irq();
    wr(PCL_ADDR_BWC, 8'h80);
    wr(PCL_ADDR_CTRL, 8'h80);
    drv(1'b1, 1'b0, 1'b0, 1'b0);
    chk({31'h0, pll_irq}, 32'h1);
    rd(PCL_ADDR_BWC, 32'hC0);
    rd(PCL_ADDR_CTRL, 32'hC0);
    rd(PCL_ADDR_CTRL, 32'h80);
    wr(PCL_ADDR_CTRL, 8'h00);
    drv(1'b0, 1'b0, 1'b0, 1'b0);
    chk({31'h0, pll_irq}, 32'h0);
    rd(PCL_ADDR_CTRL, 32'h40);
    drv(1'b1, 1'b0, 1'b1, 1'b0);
    rd(PCL_ADDR_CTRL, 32'h40);
    rd(PCL_ADDR_CTRL, 32'h40);
    drv(1'b1, 1'b0, 1'b1, 1'b1);
    rd(PCL_ADDR_CTRL, 32'h40);
    rd(PCL_ADDR_CTRL, 32'h00);
    drv(1'b0, 1'b0, 1'b0, 1'b0);
    wr(PCL_ADDR_BWC, 8'h00);
    rd(PCL_ADDR_CTRL, 32'h00);
    rd(PCL_ADDR_BWC, 32'h00);
  endtask : t_irq

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_prog();
    t_acq();
    t_irq();
    end_sim();
  end
endmodule : pcl_top_bench
